// ### verilog/bxj_pkg.sv
// What this block does
// - R0-R3 bank one, R4-R11 bank two
// - bank one select: 0 main, 1 alternate
// - bank two select: 0 main, 1 alternate
// - inactive copies keep their contents
// - jump only when selected flag equals state bit
// - sign-extend 8-bit displacement, add to counter
// - displacement adds to next instruction address
// - flag select codes map zero through tx full
// - data-available code 6 mapped by decode
// - condition-code forms reduce to flag tests
// - transceiver forms test flag one or zero
// - untaken jump takes two cycles
// - taken jump takes three cycles
package bxj_pkg;

  // ----------------------------------------------------------------
  // instruction formats
  // ----------------------------------------------------------------
  localparam logic [3:0] JUMP_OPCODE = 4'hd;
  localparam logic [8:0] SWAP_OPCODE = 9'h15d;
  localparam logic [2:0] SWAP_LOW    = 3'h0;

  typedef struct packed {
    logic [3:0] opcode;
    logic       wantState;
    logic [2:0] flagSel;
    logic [7:0] disp;
  } bxj_jump_t;

  typedef struct packed {
    logic [8:0] opcode;
    logic [1:0] irqCtl;
    logic       firstSel;
    logic       secondSel;
    logic [2:0] low;
  } bxj_swap_t;

  localparam logic [1:0] IRQ_KEEP     = 2'h0;
  localparam logic [1:0] IRQ_RESERVED = 2'h1;
  localparam logic [1:0] IRQ_SET      = 2'h2;
  localparam logic [1:0] IRQ_CLEAR    = 2'h3;

  // flag select codes
  localparam logic [2:0] SEL_ZERO     = 3'h0;
  localparam logic [2:0] SEL_CARRY    = 3'h1;
  localparam logic [2:0] SEL_OVERFLOW = 3'h2;
  localparam logic [2:0] SEL_NEGATIVE = 3'h3;
  localparam logic [2:0] SEL_RX_ACT   = 3'h4;
  localparam logic [2:0] SEL_RX_ERR   = 3'h5;
  localparam logic [2:0] SEL_RX_DATA  = 3'h6;
  localparam logic [2:0] SEL_TX_FULL  = 3'h7;

  // flag bit positions in condition_code_reg and transceiver_status_reg
  localparam int CCR_ZERO_BIT = 0;
  localparam int CCR_CARRY_BIT = 1;
  localparam int CCR_OVERFLOW_BIT = 2;
  localparam int CCR_NEGATIVE_BIT = 3;
  localparam int TSR_DATA_AVAIL_BIT = 3;
  localparam int TSR_RX_ACTIVE_BIT = 4;
  localparam int TSR_RX_ERROR_BIT = 5;
  localparam int TSR_TX_FULL_BIT = 7;

  // ----------------------------------------------------------------
  // register banks
  // ----------------------------------------------------------------
  localparam int NUM_SWITCHED = 12;
  localparam int FIRST_BANK_SIZE = 4;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } bxj_reg_req_t;

  localparam logic [ADDR_W-1:0] REG_LAST_GPR   = 5'h0b;
  localparam logic [ADDR_W-1:0] REG_CCR        = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_TSR        = 5'h0d;
  localparam logic [ADDR_W-1:0] REG_CTRL       = 5'h0e;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 5'h0f;
  localparam logic [ADDR_W-1:0] REG_PC_LO      = 5'h10;
  localparam logic [ADDR_W-1:0] REG_PC_HI      = 5'h11;
  localparam logic [ADDR_W-1:0] REG_CNT_TAKEN  = 5'h12;
  localparam logic [ADDR_W-1:0] REG_CNT_SKIP   = 5'h13;
  localparam logic [ADDR_W-1:0] REG_CNT_SWAP   = 5'h14;

  localparam int CTRL_RUN_BIT = 0;
  localparam int ST_FIRST_ALT_BIT = 0;
  localparam int ST_SECOND_ALT_BIT = 1;
  localparam int ST_IRQ_EN_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_RESERVED_BIT = 4;
  localparam int ST_UNKNOWN_BIT = 5;

  localparam logic [7:0]  CCR_RESET  = 8'h00;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] PC_STEP    = 16'h0001;
  localparam logic [7:0]  CNT_STEP   = 8'h01;

  // one-hot execution states, one per instruction cycle
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_EXEC   = 3'b010,
    ST_BRANCH = 3'b100
  } bxj_state_t;

endpackage

// ### verilog/bxj_bank_regs.sv
`timescale 1ns/1ps
`default_nettype none
module bxj_bank_regs
  import bxj_pkg::*;
(
  input  wire logic       clk,       // core clock
  input  wire logic       rst,       // async reset, active high
  input  wire logic       firstAlt,  // bank one uses alternate copy
  input  wire logic       secondAlt, // bank two uses alternate copy
  input  wire logic       wrEn,      // write active copy
  input  wire logic [3:0] wrIdx,     // register index to write
  input  wire logic [7:0] wrData,    // write value
  input  wire logic [3:0] rdIdx,     // register index to read
  output logic      [7:0] rdData     // active copy value
);

  logic [7:0] active [NUM_SWITCHED];

  // ----------------------------------------------------------------
  // main and alternate copy per switched register
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_SWITCHED; i++) begin : gReg
    logic [7:0] main_q;
    logic [7:0] alt_q;
    logic       useAlt;
    assign useAlt = (i < FIRST_BANK_SIZE) ? firstAlt : secondAlt;
    // only the active copy is ever written, the other one holds
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        main_q <= 8'h00;
        alt_q  <= 8'h00;
      end else if (wrEn && wrIdx == 4'(i)) begin
        if (useAlt) begin
          alt_q <= wrData;
        end else begin
          main_q <= wrData;
        end
      end
    end
    assign active[i] = useAlt ? alt_q : main_q;
  end

  assign rdData = (rdIdx <= REG_LAST_GPR[3:0]) ? active[rdIdx] : 8'h00;

endmodule
`default_nettype wire

// ### verilog/bxj_flag_select.sv
`timescale 1ns/1ps
`default_nettype none
module bxj_flag_select
  import bxj_pkg::*;
(
  input  wire logic [7:0] condition_code_reg,       // condition_code_reg
  input  wire logic [7:0] transceiver_status_reg,       // transceiver_status_reg
  input  wire logic [2:0] flagSel,   // flag select field
  input  wire logic       wantState, // required flag state
  output logic            met        // condition met
);

  logic flag;

  // select code and bit position differ for data available
  always_comb begin
    case (flagSel)
      SEL_ZERO:     flag = condition_code_reg[CCR_ZERO_BIT];
      SEL_CARRY:    flag = condition_code_reg[CCR_CARRY_BIT];
      SEL_OVERFLOW: flag = condition_code_reg[CCR_OVERFLOW_BIT];
      SEL_NEGATIVE: flag = condition_code_reg[CCR_NEGATIVE_BIT];
      SEL_RX_ACT:   flag = transceiver_status_reg[TSR_RX_ACTIVE_BIT];
      SEL_RX_ERR:   flag = transceiver_status_reg[TSR_RX_ERROR_BIT];
      SEL_RX_DATA:  flag = transceiver_status_reg[TSR_DATA_AVAIL_BIT];
      default:      flag = transceiver_status_reg[TSR_TX_FULL_BIT];
    endcase
  end

  assign met = (flag == wantState);

endmodule
`default_nettype wire

// ### verilog/bxj_exec_unit.sv
`timescale 1ns/1ps
`default_nettype none
module bxj_exec_unit
  import bxj_pkg::*;
(
  input  wire logic         clk,         // core clock, 250 MHz
  input  wire logic         rst,         // async reset, active high
  // instruction stream
  input  wire logic         instrValid,  // instruction word present
  input  wire logic [15:0]  instrWord,   // instruction word
  output logic              instrReady,  // unit takes the word
  output logic      [15:0]  pcOut,       // address of next instruction
  // transceiver side
  input  wire logic [7:0]   tsrIn,       // transceiver_status_reg value
  // register port
  input  wire bxj_reg_req_t regReq,      // address, data and strobes
  output logic      [7:0]   regRdata,    // read data, cycle after read
  // state outputs
  output logic              irqEnable,   // global_irq_enable
  output logic              firstAltOut, // bank one alternate active
  output logic              secondAltOut // bank two alternate active
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bxj_state_t state_q;
  logic [15:0] instr_q;
  logic [15:0] pc_q;
  logic [7:0]  ccr_q;
  logic [7:0]  ctrl_q;
  logic        firstAlt_q;
  logic        secondAlt_q;
  logic        irqEn_q;
  logic        reservedSeen_q;
  logic        unknownSeen_q;
  logic [7:0]  cntTaken_q;
  logic [7:0]  cntSkip_q;
  logic [7:0]  cntSwap_q;
  logic [7:0]  rdata_q;

  bxj_jump_t   jumpFmt;
  bxj_swap_t   swapFmt;
  logic        isJump;
  logic        isSwap;
  logic        condMet;
  logic        takeInstr;
  logic        busy;
  logic [15:0] dispExt;
  logic [7:0]  gprRdata;
  logic        gprWrite;

  assign jumpFmt = bxj_jump_t'(instr_q);
  assign swapFmt = bxj_swap_t'(instr_q);
  assign isJump  = (jumpFmt.opcode == JUMP_OPCODE);
  assign isSwap  = (swapFmt.opcode == SWAP_OPCODE) && (swapFmt.low == SWAP_LOW);

  assign busy       = (state_q != ST_IDLE);
  assign instrReady = !busy && ctrl_q[CTRL_RUN_BIT];
  assign takeInstr  = instrValid && instrReady;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  bxj_flag_select uFlag (
    .condition_code_reg       (ccr_q),
    .transceiver_status_reg       (tsrIn),
    .flagSel   (jumpFmt.flagSel),
    .wantState (jumpFmt.wantState),
    .met       (condMet)
  );

  assign gprWrite = regReq.wr && (regReq.addr <= REG_LAST_GPR);

  bxj_bank_regs uRegs (
    .clk       (clk),
    .rst       (rst),
    .firstAlt  (firstAlt_q),
    .secondAlt (secondAlt_q),
    .wrEn      (gprWrite),
    .wrIdx     (regReq.addr[3:0]),
    .wrData    (regReq.wdata),
    .rdIdx     (regReq.addr[3:0]),
    .rdData    (gprRdata)
  );

  // ----------------------------------------------------------------
  // instruction sequencing
  // ----------------------------------------------------------------
  // word taken in the first cycle, acted on in the second,
  // a taken jump spends a third cycle loading the counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (takeInstr) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (isJump && condMet) begin
            state_q <= ST_BRANCH;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_BRANCH: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_q <= 16'h0000;
    end else if (takeInstr) begin
      instr_q <= instrWord;
    end
  end

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  assign dispExt = {{8{jumpFmt.disp[7]}}, jumpFmt.disp};

  // the counter already points past the jump when the sum is formed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= PC_RESET;
    end else if (takeInstr) begin
      pc_q <= pc_q + PC_STEP;
    end else if (state_q == ST_BRANCH) begin
      pc_q <= pc_q + dispExt;
    end else if (!busy && regReq.wr && regReq.addr == REG_PC_LO) begin
      pc_q <= {pc_q[15:8], regReq.wdata};
    end else if (!busy && regReq.wr && regReq.addr == REG_PC_HI) begin
      pc_q <= {regReq.wdata, pc_q[7:0]};
    end
  end

  assign pcOut = pc_q;

  // ----------------------------------------------------------------
  // bank selection and interrupt enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      firstAlt_q  <= 1'b0;
      secondAlt_q <= 1'b0;
    end else if (state_q == ST_EXEC && isSwap) begin
      firstAlt_q  <= swapFmt.firstSel;
      secondAlt_q <= swapFmt.secondSel;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqEn_q <= 1'b0;
    end else if (state_q == ST_EXEC && isSwap) begin
      case (swapFmt.irqCtl)
        IRQ_SET:   irqEn_q <= 1'b1;
        IRQ_CLEAR: irqEn_q <= 1'b0;
        default:   irqEn_q <= irqEn_q;
      endcase
    end
  end

  assign irqEnable    = irqEn_q;
  assign firstAltOut  = firstAlt_q;
  assign secondAltOut = secondAlt_q;

  // ----------------------------------------------------------------
  // condition codes
  // ----------------------------------------------------------------
  // only software loads the codes; neither instruction touches them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ccr_q <= CCR_RESET;
    end else if (regReq.wr && regReq.addr == REG_CCR) begin
      ccr_q <= regReq.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (regReq.wr && regReq.addr == REG_CTRL) begin
      ctrl_q <= regReq.wdata;
    end
  end

  // ----------------------------------------------------------------
  // sticky status, write one to clear, a new event wins the clear
  // ----------------------------------------------------------------
  logic statusWr;
  logic reservedEvt;
  logic unknownEvt;

  assign statusWr    = regReq.wr && regReq.addr == REG_STATUS;
  assign reservedEvt = state_q == ST_EXEC && isSwap && swapFmt.irqCtl == IRQ_RESERVED;
  assign unknownEvt  = state_q == ST_EXEC && !isSwap && !isJump;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reservedSeen_q <= 1'b0;
    end else if (reservedEvt) begin
      reservedSeen_q <= 1'b1;
    end else if (statusWr && regReq.wdata[ST_RESERVED_BIT]) begin
      reservedSeen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unknownSeen_q <= 1'b0;
    end else if (unknownEvt) begin
      unknownSeen_q <= 1'b1;
    end else if (statusWr && regReq.wdata[ST_UNKNOWN_BIT]) begin
      unknownSeen_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // activity counters, wrap at 8 bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cntTaken_q <= 8'h00;
      cntSkip_q  <= 8'h00;
      cntSwap_q  <= 8'h00;
    end else if (state_q == ST_EXEC) begin
      if (isJump && condMet) begin
        cntTaken_q <= cntTaken_q + CNT_STEP;
      end else if (isJump) begin
        cntSkip_q <= cntSkip_q + CNT_STEP;
      end else if (isSwap) begin
        cntSwap_q <= cntSwap_q + CNT_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [7:0] statusVal;

  always_comb begin
    statusVal                    = 8'h00;
    statusVal[ST_FIRST_ALT_BIT]  = firstAlt_q;
    statusVal[ST_SECOND_ALT_BIT] = secondAlt_q;
    statusVal[ST_IRQ_EN_BIT]     = irqEn_q;
    statusVal[ST_BUSY_BIT]       = busy;
    statusVal[ST_RESERVED_BIT]   = reservedSeen_q;
    statusVal[ST_UNKNOWN_BIT]    = unknownSeen_q;
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (!regReq.rd) begin
      rdata_q <= 8'h00;
    end else if (regReq.addr <= REG_LAST_GPR) begin
      rdata_q <= gprRdata;
    end else if (regReq.addr == REG_CCR) begin
      rdata_q <= ccr_q;
    end else if (regReq.addr == REG_TSR) begin
      rdata_q <= tsrIn;
    end else if (regReq.addr == REG_CTRL) begin
      rdata_q <= ctrl_q;
    end else if (regReq.addr == REG_STATUS) begin
      rdata_q <= statusVal;
    end else if (regReq.addr == REG_PC_LO) begin
      rdata_q <= pc_q[7:0];
    end else if (regReq.addr == REG_PC_HI) begin
      rdata_q <= pc_q[15:8];
    end else if (regReq.addr == REG_CNT_TAKEN) begin
      rdata_q <= cntTaken_q;
    end else if (regReq.addr == REG_CNT_SKIP) begin
      rdata_q <= cntSkip_q;
    end else if (regReq.addr == REG_CNT_SWAP) begin
      rdata_q <= cntSwap_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign regRdata = rdata_q;

endmodule
`default_nettype wire

// ### testbench/bxj_exec_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bxj_exec_unit_assertions
  import bxj_pkg::*;
(
  input wire logic         clk,          // core clock
  input wire logic         rst,          // async reset, active high
  input wire logic         instrValid,   // instruction word present
  input wire logic [15:0]  instrWord,    // instruction word
  input wire logic         instrReady,   // unit takes the word
  input wire logic [15:0]  pcOut,        // next fetch address
  input wire logic [7:0]   tsrIn,        // transceiver status
  input wire bxj_reg_req_t regReq,       // register port request
  input wire logic [7:0]   regRdata,     // register read data
  input wire logic         irqEnable,    // global irq enable
  input wire logic         firstAltOut,  // bank one alternate
  input wire logic         secondAltOut  // bank two alternate
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic        take;
  logic        isSwap;
  logic        isJump;
  logic [15:0] nxt_q;
  logic [15:0] tgt_q;

  assign take   = instrValid && instrReady;
  assign isSwap = (instrWord[15:7] == SWAP_OPCODE) && (instrWord[2:0] == SWAP_LOW);
  assign isJump = (instrWord[15:12] == JUMP_OPCODE);

  // both landing points are captured at the take edge, before pcOut moves
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nxt_q <= 16'h0000;
      tgt_q <= 16'h0000;
    end else if (take) begin
      nxt_q <= pcOut + 16'h0001;
      tgt_q <= pcOut + 16'h0001 + {{8{instrWord[7]}}, instrWord[7:0]};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_pc_next_step: assert property (take |=> pcOut == nxt_q)
    else $error("pc did not step to next word");
  a_jump_target: assert property (take && isJump |-> ##2 ((instrReady && pcOut == nxt_q)
    or (!instrReady ##1 (instrReady && pcOut == tgt_q))))
    else $error("jump landed at wrong address");
  a_jump_length: assert property (take && isJump |=> !instrReady ##[1:2] instrReady)
    else $error("jump length not two or three cycles");
  a_swap_length: assert property (take && isSwap |=> !instrReady ##1 instrReady)
    else $error("exchange length not two cycles");
  a_first_select: assert property (take && isSwap |-> ##2 firstAltOut == $past(instrWord[4], 2))
    else $error("bank one select wrong");
  a_second_select: assert property (take && isSwap |-> ##2 secondAltOut == $past(instrWord[3], 2))
    else $error("bank two select wrong");
  a_irq_set: assert property (take && isSwap && instrWord[6:5] == IRQ_SET |-> ##2 irqEnable)
    else $error("irq enable not set");
  a_irq_clear: assert property (take && isSwap && instrWord[6:5] == IRQ_CLEAR |-> ##2 !irqEnable)
    else $error("irq enable not cleared");
  a_irq_keep: assert property (take && isSwap && !instrWord[6] |-> ##2 irqEnable == $past(irqEnable, 2))
    else $error("irq enable changed by keep code");
  a_bank_stable: assert property ($changed(firstAltOut) || $changed(secondAltOut)
    |-> $past(take && isSwap, 2))
    else $error("bank select moved without exchange");

  c_swap_taken: cover property (take && isSwap);
  c_jump_long:  cover property (take && isJump ##2 !instrReady);
  c_reg_read:   cover property (regReq.rd ##1 regRdata != 8'h00);
endmodule

bind bxj_exec_unit bxj_exec_unit_assertions bxj_exec_unit_assertions_inst (
  .clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
  .instrReady(instrReady), .pcOut(pcOut), .tsrIn(tsrIn), .regReq(regReq),
  .regRdata(regRdata), .irqEnable(irqEnable), .firstAltOut(firstAltOut),
  .secondAltOut(secondAltOut)
);
`default_nettype wire

// ### testbench/bxj_exec_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bxj_exec_unit_tb
  import bxj_pkg::*;
;
  logic         clk;
  logic         rst;
  logic         instrValid;
  logic [15:0]  instrWord;
  logic         instrReady;
  logic [15:0]  pcOut;
  logic [7:0]   tsrIn;
  bxj_reg_req_t regReq;
  logic [7:0]   regRdata;
  logic         irqEnable;
  logic         firstAltOut;
  logic         secondAltOut;
  int           n_mismatch;
  int           compares;
  int           cycles;

  bxj_exec_unit bxj_exec_unit_inst (
    .clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
    .instrReady(instrReady), .pcOut(pcOut), .tsrIn(tsrIn), .regReq(regReq),
    .regRdata(regRdata), .irqEnable(irqEnable), .firstAltOut(firstAltOut),
    .secondAltOut(secondAltOut)
  );

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // whole run needs well under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic regWr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq <= '0;
  endtask

  task automatic regRd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq <= '0;
    @(negedge clk);
    d = regRdata;
  endtask

  // n counts cycles from the take edge until the unit is ready again
  task automatic exec(input logic [15:0] w, output int n);
    int g;
    g = 0;
    do begin @(negedge clk); g++; end while (instrReady !== 1'b1 && g < 20);
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord  <= w;
    @(posedge clk);
    instrValid <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (instrReady !== 1'b1 && n < 20);
  endtask

  function automatic logic [15:0] swapW(input logic [1:0] g, input logic a, input logic b);
    return {SWAP_OPCODE, g, a, b, SWAP_LOW};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic resetTest();
    logic [7:0] d;
    @(negedge clk);
    check("pc at reset", pcOut, 16'h0000);
    check("ready while stopped", {15'h0, instrReady}, 16'h0000);
    regRd(REG_STATUS, d);
    check("status at reset", {8'h0, d}, 16'h0000);
    regWr(5'h1f, 8'h5a);
    regRd(5'h1f, d);
    check("unmapped read", {8'h0, d}, 16'h0000);
  endtask

  task automatic bankTest();
    logic [7:0] d;
    int         n;
    regWr(5'h00, 8'h11);
    regWr(5'h03, 8'h33);
    regWr(5'h04, 8'h44);
    exec(swapW(IRQ_KEEP, 1'b1, 1'b0), n);
    check("swap cycles", 16'(n), 16'd2);
    check("bank selects", {14'h0, firstAltOut, secondAltOut}, 16'h0002);
    regRd(5'h03, d);
    check("alternate R3", {8'h0, d}, 16'h0000);
    regRd(5'h04, d);
    check("main R4", {8'h0, d}, 16'h0044);
    regWr(5'h00, 8'haa);
    exec(swapW(IRQ_KEEP, 1'b0, 1'b1), n);
    check("bank selects", {14'h0, firstAltOut, secondAltOut}, 16'h0001);
    regRd(5'h00, d);
    check("main R0 kept", {8'h0, d}, 16'h0011);
    regRd(5'h0b, d);
    check("alternate R11", {8'h0, d}, 16'h0000);
    regWr(5'h04, 8'hbb);
    exec(swapW(IRQ_KEEP, 1'b1, 1'b0), n);
    regRd(5'h00, d);
    check("alternate R0 kept", {8'h0, d}, 16'h00aa);
    regRd(5'h04, d);
    check("main R4 kept", {8'h0, d}, 16'h0044);
  endtask

  task automatic irqTest();
    logic [1:0] codes [5];
    logic       expIrq [5];
    logic [7:0] d;
    int         n;
    codes  = '{IRQ_SET, IRQ_KEEP, IRQ_RESERVED, IRQ_CLEAR, IRQ_KEEP};
    expIrq = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    regWr(REG_CCR, 8'h0f);
    for (int i = 0; i < 5; i++) begin
      exec(swapW(codes[i], 1'b0, 1'b0), n);
      check("irq enable", {15'h0, irqEnable}, {15'h0, expIrq[i]});
    end
    regRd(REG_STATUS, d);
    check("reserved code seen", {15'h0, d[ST_RESERVED_BIT]}, 16'h0001);
    regRd(REG_CCR, d);
    check("flags after exchange", {8'h0, d}, 16'h000f);
  endtask

  task automatic jumpTest();
    int         bitPos [8];
    logic [7:0] pat;
    logic [7:0] disp;
    logic [7:0] d;
    logic       met;
    int         n;
    bitPos = '{CCR_ZERO_BIT, CCR_CARRY_BIT, CCR_OVERFLOW_BIT, CCR_NEGATIVE_BIT,
               TSR_RX_ACTIVE_BIT, TSR_RX_ERROR_BIT, TSR_DATA_AVAIL_BIT, TSR_TX_FULL_BIT};
    for (int s = 0; s < 8; s++) begin
      for (int st = 0; st < 2; st++) begin
        for (int fl = 0; fl < 2; fl++) begin
          // every other bit holds the opposite level, and so does the unselected register
          pat = 8'h01 << bitPos[s];
          if (fl == 0) pat = ~pat;
          regWr(REG_CCR, (s < 4) ? pat : ~pat);
          tsrIn <= (s < 4) ? ~pat : pat;
          regWr(REG_PC_LO, 8'h40);
          regWr(REG_PC_HI, 8'h12);
          disp = (st == 1) ? 8'h80 : 8'h7f;
          met = (st == fl);
          exec({JUMP_OPCODE, 1'(st), 3'(s), disp}, n);
          check("jump pc", pcOut,
                16'h1241 + (met ? {{8{disp[7]}}, disp} : 16'h0000));
          check("jump cycles", 16'(n), met ? 16'd3 : 16'd2);
        end
      end
    end
    regRd(REG_CCR, d);
    check("flags after jump", {8'h0, d}, {8'h0, ~pat});
  endtask

  // unknown word, sticky status with write-one-clear, activity counters
  task automatic statusTest();
    logic [7:0] d;
    int         n;
    exec(16'h0000, n);
    check("unknown cycles", 16'(n), 16'd2);
    check("unknown pc", pcOut, 16'h11c2);
    regRd(REG_STATUS, d);
    check("status sticky", {8'h0, d}, 16'h0030);
    regWr(REG_STATUS, 8'h30);
    regRd(REG_STATUS, d);
    check("status cleared", {8'h0, d}, 16'h0000);
    regRd(REG_CNT_TAKEN, d);
    check("taken count", {8'h0, d}, 16'h0010);
    regRd(REG_CNT_SKIP, d);
    check("skip count", {8'h0, d}, 16'h0010);
    regRd(REG_CNT_SWAP, d);
    check("swap count", {8'h0, d}, 16'h0008);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst        = 1'b1;
    instrValid = 1'b0;
    instrWord  = 16'h0000;
    tsrIn      = 8'h00;
    regReq     = '0;
    n_mismatch = 0;
    compares   = 0;
    cycles     = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    resetTest();
    regWr(REG_CTRL, 8'h01);
    bankTest();
    irqTest();
    jumpTest();
    statusTest();
    test_done();
  end
endmodule
`default_nettype wire
